// ===== design/port4_strobe.sv
// What this block does
// - Mode zero makes a pin ordinary quasi-bidirectional I/O.
// - Reset leaves every pin in I/O mode with no strobe active.
// - Mode one gives a read strobe on matching external data reads.
// - Mode two gives a write strobe on matching external data writes.
// - Mode three strobes on matching reads or writes.
// - Each pin has a 16-bit comparator from high and low byte registers.
// - Two control registers choose each pin's operating mode.
// - Control field can exclude lowest address lines to cover a block.
// - Strobes are active low; a per-pin invert bit makes them high.
// - Data register writes drive only pins in I/O mode.
// - Pin three doubles as a reboot request from the loader flash.
// - Strobes follow the external data read and write strobes.
//
// Purpose: Four-pin port with address-decoded chip-select strobes.
// Assumes: Core special register bus: address, write pulse, data in and out.
// Notes:   Output enable is low while a pin is driven; high means weak pull-up.
`timescale 1ns/100ps
module port4_strobe #(
    parameter int PINS = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // Special register bus
    input  wire logic [7:0]       sfr_addr_i,
    input  wire logic             sfr_wr_i,
    input  wire logic [7:0]       sfr_wdata_i,
    output logic      [7:0]       sfr_rdata_o,
    // External data access from the core
    input  wire logic [15:0]      ext_addr_i,
    input  wire logic             ext_rd_n_i,
    input  wire logic             ext_wr_n_i,
    // Reboot path
    input  wire logic             reboot_enable_i,
    output logic                  reboot_o,
    // Pins
    input  wire logic [PINS-1:0]  pin_i,
    output logic      [PINS-1:0]  pin_o,
    output logic      [PINS-1:0]  pin_oe_n_o
);

    // Register state
    logic [PINS-1:0] pin_data;
    logic [PINS-1:0] next_pin_data;
    logic [7:0]      ctrl_a;
    logic [7:0]      next_ctrl_a;
    logic [7:0]      ctrl_b;
    logic [7:0]      next_ctrl_b;
    logic [7:0]      addr_lo [PINS];
    logic [7:0]      next_addr_lo [PINS];
    logic [7:0]      addr_hi [PINS];
    logic [7:0]      next_addr_hi [PINS];
    logic [PINS-1:0] invert;
    logic [PINS-1:0] next_invert;
    logic            pin3_prev;
    logic            next_pin3_prev;
    logic            reboot_armed;
    logic            next_reboot;

    logic [15:0]     ctrl_all;
    logic [PINS-1:0] strobe;
    logic [PINS-1:0] is_gpio;
    port4_strobe_pkg::ext_access_t acc;
    port4_strobe_pkg::strobe_cfg_t cfg [PINS];

    // Address decode for the per-pin comparator bytes
    function automatic logic [7:0] lo_addr(input int idx);
        logic [7:0] a;
        a = port4_strobe_pkg::ADDR_PIN0_ADDR_LO;
        unique case (idx)
            0: a = port4_strobe_pkg::ADDR_PIN0_ADDR_LO;
            1: a = port4_strobe_pkg::ADDR_PIN1_ADDR_LO;
            2: a = port4_strobe_pkg::ADDR_PIN2_ADDR_LO;
            default: a = port4_strobe_pkg::ADDR_PIN3_ADDR_LO;
        endcase
        return a;
    endfunction

    function automatic logic [7:0] hi_addr(input int idx);
        logic [7:0] a;
        a = port4_strobe_pkg::ADDR_PIN0_ADDR_HI;
        unique case (idx)
            0: a = port4_strobe_pkg::ADDR_PIN0_ADDR_HI;
            1: a = port4_strobe_pkg::ADDR_PIN1_ADDR_HI;
            2: a = port4_strobe_pkg::ADDR_PIN2_ADDR_HI;
            default: a = port4_strobe_pkg::ADDR_PIN3_ADDR_HI;
        endcase
        return a;
    endfunction

    assign ctrl_all = {ctrl_b, ctrl_a};
    assign acc      = '{addr: ext_addr_i, rd_n: ext_rd_n_i, wr_n: ext_wr_n_i};

    // Per-pin configuration and strobe decoders
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : gen_pin
            localparam int B = g * port4_strobe_pkg::CTRL_FIELD_W;
            assign cfg[g].mode = port4_strobe_pkg::pin_mode_t'(
                ctrl_all[B + port4_strobe_pkg::MODE_LSB +: 2]);
            assign cfg[g].mask   = ctrl_all[B + port4_strobe_pkg::MASK_LSB +: 2];
            assign cfg[g].invert = invert[g];
            assign cfg[g].base   = {addr_hi[g], addr_lo[g]};
            assign is_gpio[g]    = cfg[g].mode == port4_strobe_pkg::MODE_GPIO;

            pin_strobe_decode u_dec (
                .cfg_i    (cfg[g]),
                .acc_i    (acc),
                .strobe_o (strobe[g]),
                .active_o ()
            );
        end
    endgenerate

    // Register writes
    always_comb begin
        next_pin_data = pin_data;
        next_ctrl_a   = ctrl_a;
        next_ctrl_b   = ctrl_b;
        next_invert   = invert;
        next_addr_lo  = addr_lo;
        next_addr_hi  = addr_hi;
        if (sfr_wr_i) begin
            unique case (sfr_addr_i)
                port4_strobe_pkg::ADDR_PIN_DATA:    next_pin_data = sfr_wdata_i[PINS-1:0];
                port4_strobe_pkg::ADDR_MODE_CTRL_A: next_ctrl_a   = sfr_wdata_i;
                port4_strobe_pkg::ADDR_MODE_CTRL_B: next_ctrl_b   = sfr_wdata_i;
                port4_strobe_pkg::ADDR_POLARITY:
                    next_invert = sfr_wdata_i[port4_strobe_pkg::INVERT_LSB +: PINS];
                default: begin
                end
            endcase
            for (int i = 0; i < PINS; i++) begin
                if (sfr_addr_i == lo_addr(i)) begin
                    next_addr_lo[i] = sfr_wdata_i;
                end
                if (sfr_addr_i == hi_addr(i)) begin
                    next_addr_hi[i] = sfr_wdata_i;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pin_data <= port4_strobe_pkg::PIN_DATA_RST;
            ctrl_a   <= port4_strobe_pkg::CTRL_RST;
            ctrl_b   <= port4_strobe_pkg::CTRL_RST;
            invert   <= port4_strobe_pkg::INVERT_RST;
            for (int i = 0; i < PINS; i++) begin
                addr_lo[i] <= port4_strobe_pkg::ADDR_BYTE_RST;
                addr_hi[i] <= port4_strobe_pkg::ADDR_BYTE_RST;
            end
        end else begin
            pin_data <= next_pin_data;
            ctrl_a   <= next_ctrl_a;
            ctrl_b   <= next_ctrl_b;
            invert   <= next_invert;
            addr_lo  <= next_addr_lo;
            addr_hi  <= next_addr_hi;
        end
    end

    // Register read mux; unimplemented bits read high
    always_comb begin
        sfr_rdata_o = port4_strobe_pkg::UNUSED_READ;
        unique case (sfr_addr_i)
            port4_strobe_pkg::ADDR_PIN_DATA:    sfr_rdata_o[PINS-1:0] = pin_i;
            port4_strobe_pkg::ADDR_MODE_CTRL_A: sfr_rdata_o = ctrl_a;
            port4_strobe_pkg::ADDR_MODE_CTRL_B: sfr_rdata_o = ctrl_b;
            port4_strobe_pkg::ADDR_POLARITY:
                sfr_rdata_o[port4_strobe_pkg::INVERT_LSB +: PINS] = invert;
            default: begin
            end
        endcase
        for (int i = 0; i < PINS; i++) begin
            if (sfr_addr_i == lo_addr(i)) begin
                sfr_rdata_o = addr_lo[i];
            end
            if (sfr_addr_i == hi_addr(i)) begin
                sfr_rdata_o = addr_hi[i];
            end
        end
    end

    // Pin drive: quasi-bidirectional in I/O mode, strong drive as strobe
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (is_gpio[i]) begin
                pin_o[i]      = pin_data[i];
                pin_oe_n_o[i] = pin_data[i];
            end else begin
                // Latch stays stored but does not reach a strobe pin
                pin_o[i]      = strobe[i];
                pin_oe_n_o[i] = 1'b0;
            end
        end
    end

    // Reboot request on a falling edge of pin three while it is a released input
    // Arming needs a set latch bit, so a low the port drives itself never reboots
    always_comb begin
        next_pin3_prev = pin_i[port4_strobe_pkg::REBOOT_PIN];
        reboot_armed   = reboot_enable_i
                         & is_gpio[port4_strobe_pkg::REBOOT_PIN]
                         & pin_data[port4_strobe_pkg::REBOOT_PIN];
        next_reboot    = reboot_armed & pin3_prev & ~next_pin3_prev;
    end

    // Edge history starts at the pull-up level, so reset gives no false edge
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pin3_prev <= 1'b1;
            reboot_o  <= 1'b0;
        end else begin
            pin3_prev <= next_pin3_prev;
            reboot_o  <= next_reboot;
        end
    end

endmodule

// ===== design/port4_strobe_pkg.sv
// Purpose: Shared constants and types for the four-pin strobe port.
// Assumes: Registers sit on the core's 8-bit special register bus.
// Notes:   Each pin has a 4-bit control field: mode in [3:2], mask in [1:0].
package port4_strobe_pkg;

    // Register addresses on the special register bus
    localparam logic [7:0] ADDR_PIN_DATA     = 8'hA5;
    localparam logic [7:0] ADDR_MODE_CTRL_A  = 8'h92;
    localparam logic [7:0] ADDR_MODE_CTRL_B  = 8'h93;
    localparam logic [7:0] ADDR_PIN0_ADDR_LO = 8'h94;
    localparam logic [7:0] ADDR_PIN0_ADDR_HI = 8'h95;
    localparam logic [7:0] ADDR_PIN1_ADDR_LO = 8'h96;
    localparam logic [7:0] ADDR_PIN1_ADDR_HI = 8'h97;
    localparam logic [7:0] ADDR_PIN2_ADDR_LO = 8'h9A;
    localparam logic [7:0] ADDR_PIN2_ADDR_HI = 8'h9B;
    localparam logic [7:0] ADDR_PIN3_ADDR_LO = 8'h9C;
    localparam logic [7:0] ADDR_PIN3_ADDR_HI = 8'h9D;
    localparam logic [7:0] ADDR_POLARITY     = 8'hAE;

    // Field positions
    localparam int CTRL_FIELD_W  = 4;
    localparam int MODE_LSB      = 2;
    localparam int MASK_LSB      = 0;
    localparam int INVERT_LSB    = 4;
    localparam int REBOOT_PIN    = 3;

    // Values after reset
    localparam logic [3:0] PIN_DATA_RST  = 4'hF;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] ADDR_BYTE_RST = 8'h00;
    localparam logic [3:0] INVERT_RST    = 4'h0;
    localparam logic [7:0] UNUSED_READ   = 8'hFF;

    // Pin operating modes
    typedef enum logic [1:0] {
        MODE_GPIO   = 2'h0,
        MODE_READ   = 2'h1,
        MODE_WRITE  = 2'h2,
        MODE_RDWR   = 2'h3
    } pin_mode_t;

    // Per-pin strobe configuration
    typedef struct packed {
        pin_mode_t   mode;
        logic [1:0]  mask;
        logic        invert;
        logic [15:0] base;
    } strobe_cfg_t;

    // External data bus access as seen by the comparators
    typedef struct packed {
        logic [15:0] addr;
        logic        rd_n;
        logic        wr_n;
    } ext_access_t;

endpackage

// ===== design/pin_strobe_decode.sv
// Purpose: One pin's address comparator and strobe generator.
// Assumes: Access strobes are active low and address is stable under them.
// Notes:   Output level is combinational so it tracks the access strobes.
`timescale 1ns/100ps
module pin_strobe_decode (
    input  wire port4_strobe_pkg::strobe_cfg_t cfg_i,
    input  wire port4_strobe_pkg::ext_access_t acc_i,
    output logic                               strobe_o,
    output logic                               active_o
);

    // Mask code n drops the lowest address lines from the compare
    function automatic logic [15:0] low_mask(input logic [1:0] code);
        logic [15:0] m;
        m = 16'hFFFF;
        unique case (code)
            2'h0: m = 16'hFFFF;
            2'h1: m = 16'hFFFE;
            2'h2: m = 16'hFFFC;
            2'h3: m = 16'hFFF8;
        endcase
        return m;
    endfunction

    logic        hit;
    logic        rd_act;
    logic        wr_act;
    logic [15:0] m;

    // Compare, qualify by access type, then apply polarity
    always_comb begin
        m      = low_mask(cfg_i.mask);
        hit    = ((acc_i.addr ^ cfg_i.base) & m) == 16'h0000;
        rd_act = ~acc_i.rd_n;
        wr_act = ~acc_i.wr_n;
        active_o = 1'b0;
        unique case (cfg_i.mode)
            port4_strobe_pkg::MODE_GPIO:  active_o = 1'b0;
            port4_strobe_pkg::MODE_READ:  active_o = hit & rd_act;
            port4_strobe_pkg::MODE_WRITE: active_o = hit & wr_act;
            port4_strobe_pkg::MODE_RDWR:  active_o = hit & (rd_act | wr_act);
        endcase
        // Idle level is high unless inverted; mismatch keeps idle
        strobe_o = active_o ^ ~cfg_i.invert;
    end

endmodule

// ===== verification/port4_strobe_chk.sv
// Purpose: Port-level checks for the four-pin strobe port.
// Assumes: Only top ports are visible; state is inferred from bus traffic.
// Notes:   Bound into every port4_strobe instance.
`timescale 1ns/100ps
module port4_strobe_chk #(
    parameter int PINS = 4
) (
    input wire logic            clk_i,
    input wire logic            rstn_i,
    input wire logic [7:0]      sfr_addr_i,
    input wire logic            sfr_wr_i,
    input wire logic [7:0]      sfr_wdata_i,
    input wire logic [7:0]      sfr_rdata_o,
    input wire logic [15:0]     ext_addr_i,
    input wire logic            ext_rd_n_i,
    input wire logic            ext_wr_n_i,
    input wire logic            reboot_enable_i,
    input wire logic            reboot_o,
    input wire logic [PINS-1:0] pin_i,
    input wire logic [PINS-1:0] pin_o,
    input wire logic [PINS-1:0] pin_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Reset leaves pins released and no reboot
    property p_rst;
        disable iff (1'b0) !rstn_i |=> pin_o == '1 && pin_oe_n_o == '1 && !reboot_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_rb_pulse;
        reboot_o |=> !reboot_o;
    endproperty
    a_rb_pulse: assert property (p_rb_pulse) else $error("reboot too long");
    property p_rb_cause;
        reboot_o |-> $past(reboot_enable_i && !pin_i[3]) && $past(pin_i[3], 2)
            && $past(pin_o[3] && pin_oe_n_o[3]);
    endproperty
    a_rb_cause: assert property (p_rb_cause) else $error("reboot without fall");
    property p_ctrl_rb;
        sfr_wr_i && sfr_addr_i == port4_strobe_pkg::ADDR_MODE_CTRL_A
            ##1 sfr_addr_i == port4_strobe_pkg::ADDR_MODE_CTRL_A
            |-> sfr_rdata_o == $past(sfr_wdata_i);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("mode control lost");
    property p_lo_rb;
        sfr_wr_i && sfr_addr_i == port4_strobe_pkg::ADDR_PIN0_ADDR_LO
            ##1 sfr_addr_i == port4_strobe_pkg::ADDR_PIN0_ADDR_LO
            |-> sfr_rdata_o == $past(sfr_wdata_i);
    endproperty
    a_lo_rb: assert property (p_lo_rb) else $error("compare byte lost");
    property p_oe;
        (pin_oe_n_o & ~pin_o) == '0;
    endproperty
    a_oe: assert property (p_oe) else $error("released pin not high");
    property p_idle;
        ext_rd_n_i && ext_wr_n_i && $past(ext_rd_n_i && ext_wr_n_i) && !$past(sfr_wr_i)
            |-> $stable(pin_o);
    endproperty
    a_idle: assert property (p_idle) else $error("pin moved without access");
    property p_pol_rd;
        sfr_addr_i == port4_strobe_pkg::ADDR_POLARITY |-> sfr_rdata_o[3:0] == 4'hF;
    endproperty
    a_pol_rd: assert property (p_pol_rd) else $error("polarity spare bits");
    property p_data_rd;
        sfr_addr_i == port4_strobe_pkg::ADDR_PIN_DATA |-> sfr_rdata_o == {4'hF, pin_i};
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("data read not pins");
    // Main scenarios seen
    c_wr_strobe: cover property (!ext_wr_n_i && pin_o[0]);
    c_rd_strobe: cover property (!ext_rd_n_i && !pin_o[1]);
    c_reboot: cover property (reboot_o);
endmodule
bind port4_strobe port4_strobe_chk #(.PINS(PINS)) u_chk (.*);

// ===== verification/periph_model.sv
// Purpose: Far-side peripherals and pull-ups on the four pins.
// Assumes: A released pin floats to the pull-up level.
// Notes:   Bench may pull a pin low, as a reboot button would.
`timescale 1ns/100ps
module periph_model (
    input  wire logic [3:0] dev_out_i,
    input  wire logic [3:0] dev_oe_n_i,
    input  wire logic [3:0] pull_low_i,
    output logic      [3:0] pin_lvl_o
);
    // Wire level from device drive, pull-up and external pull
    assign pin_lvl_o = ~pull_low_i & (dev_oe_n_i | dev_out_i);
endmodule

// ===== verification/port4_chip_select_strobes_tb.sv
// Purpose: Self-checking bench for the four-pin strobe port.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Random bases and addresses come from a fixed-seed LFSR.
`timescale 1ns/100ps
module port4_chip_select_strobes_tb;
    logic        clk_i = 0, rstn_i = 0, sfr_wr = 0, rd_n = 1, wr_n = 1, rb_en = 0, reboot;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, rdata;
    logic [15:0] ext_addr = 16'h0000, seed = 16'h8670, a, b;
    logic [3:0]  pull_low = 4'h0, pin_lvl, pin_o, oe_n, f;
    logic        inv;
    int          err_total = 0, samples_checked = 0, cyc = 0;
    logic [7:0]  lo_tab [4] = '{8'h94, 8'h96, 8'h9A, 8'h9C};
    port4_strobe #(.PINS(4)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr),
        .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(rdata), .ext_addr_i(ext_addr),
        .ext_rd_n_i(rd_n), .ext_wr_n_i(wr_n), .reboot_enable_i(rb_en), .reboot_o(reboot),
        .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n_o(oe_n));
    periph_model u_periph (.dev_out_i(pin_o), .dev_oe_n_i(oe_n), .pull_low_i(pull_low),
        .pin_lvl_o(pin_lvl));
    // Clock and hang guard
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected pin level for one access
    function automatic logic exp_pin(input logic [3:0] c, input logic iv,
        input logic [15:0] bs, input logic [15:0] ad, input logic r_n, input logic w_n);
        logic [15:0] m;
        m = 16'hFFFF << c[1:0];
        return (((ad & m) == (bs & m)) && ((c[2] && !r_n) || (c[3] && !w_n))) ~^ iv;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk_i);
        sfr_addr = ad;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_i);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(negedge clk_i);
        sfr_addr = ad;
        #10;
        chk(rdata, exp, "register read");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
        chk({reboot, oe_n, pin_o}, 16'h00FF, "reset pins");
        rd(port4_strobe_pkg::ADDR_MODE_CTRL_B, 8'h00);
        rd(8'h91, 8'hFF);
        $display("test reset done");
        repeat (8) begin
            seed = lfsr(seed);
            wr(port4_strobe_pkg::ADDR_PIN_DATA, seed[7:0]);
            chk({oe_n, pin_o}, {2{seed[3:0]}}, "gpio drive");
            rd(port4_strobe_pkg::ADDR_PIN_DATA, {4'hF, seed[3:0]});
        end
        $display("test gpio done");
        for (int p = 0; p < 4; p++) begin
            for (int k = 4; k < 16; k++) begin
                seed = lfsr(seed);
                f = k[3:0];
                inv = seed[0];
                b = lfsr(seed);
                wr(port4_strobe_pkg::ADDR_MODE_CTRL_A, p < 2 ? 8'(f) << (4 * p) : 8'h00);
                wr(port4_strobe_pkg::ADDR_MODE_CTRL_B, p > 1 ? 8'(f) << (4 * p - 8) : 8'h00);
                wr(lo_tab[p], b[7:0]);
                wr(lo_tab[p] + 8'h01, b[15:8]);
                wr(port4_strobe_pkg::ADDR_POLARITY, 8'(inv) << (4 + p));
                wr(port4_strobe_pkg::ADDR_PIN_DATA, 8'h00);
                chk({oe_n, pin_o}, {4'h0, 4'(!inv) << p}, "strobe pin idle");
                rd(port4_strobe_pkg::ADDR_POLARITY, {4'(inv) << p, 4'hF});
                rd(lo_tab[p] + 8'h01, b[15:8]);
                for (int t = 0; t < 8; t++) begin
                    seed = lfsr(seed);
                    a = t < 6 ? b ^ {13'h0, seed[2:0]} : seed;
                    @(negedge clk_i);
                    ext_addr = a;
                    rd_n = t[0];
                    wr_n = !t[0];
                    #10;
                    chk(pin_o[p], exp_pin(f, inv, b, a, rd_n, wr_n), "strobe");
                    @(negedge clk_i);
                    rd_n = 1'b1;
                    wr_n = 1'b1;
                end
            end
        end
        wr(port4_strobe_pkg::ADDR_MODE_CTRL_A, 8'h00);
        wr(port4_strobe_pkg::ADDR_MODE_CTRL_B, 8'h00);
        wr(port4_strobe_pkg::ADDR_PIN_DATA, 8'h0F);
        $display("test strobe done");
        for (int e = 1; e >= 0; e--) begin
            rb_en = e[0];
            @(negedge clk_i);
            pull_low = 4'h8;
            @(negedge clk_i);
            chk(reboot, e[0], "reboot pulse");
            @(negedge clk_i);
            chk(reboot, 1'b0, "reboot end");
            pull_low = 4'h0;
        end
        rb_en = 1'b1;
        wr(port4_strobe_pkg::ADDR_PIN_DATA, 8'h07);
        @(negedge clk_i);
        chk(reboot, 1'b0, "no reboot from own drive");
        rb_en = 1'b0;
        $display("test reboot done");
        wr(port4_strobe_pkg::ADDR_PIN_DATA, 8'h00);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        chk({oe_n, pin_o}, 16'h00FF, "second reset");
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
